// ===== src/rcs_clock_guard.sv
// Clock guard: spike filter on the sampled main clock and safe clock selection.
// Assumes the main clock level arrives already synchronised through the interface.
`timescale 1ns/1ps

module rcs_clock_guard import rcs_pkg::*; #(
	parameter int unsigned FILT_CYC = FILTER_CYC,
	parameter int unsigned PERIOD_CYC = SAFE_CYC,
	parameter int unsigned RECOVER = RECOVER_PERIODS
) (
	input wire logic core_clk,
	input wire logic arst_n,
	rcs_guard_if.guard g
);

	typedef struct packed {
		logic last;
		logic [7:0] phase;
		logic [15:0] per;
		logic seen;
		logic [3:0] good;
		logic safe;
		logic entry;
		logic ok;
	} rcs_guard_s;

	rcs_guard_s s_q;
	rcs_guard_s s_d;
	logic edge_ok;

	always_comb begin
		s_d = s_q;
		s_d.entry = 1'b0;
		edge_ok = (g.osc_lvl != s_q.last) && (s_q.phase >= 8'(FILT_CYC));
		if (!g.en) begin
			s_d = '0;
			s_d.last = g.osc_lvl;
		end else begin
			s_d.last = g.osc_lvl;
			if (g.osc_lvl != s_q.last) begin
				s_d.phase = 8'h01;
			end else if (s_q.phase != 8'hFF) begin
				s_d.phase = s_q.phase + 8'h01;
			end
			if (edge_ok) begin
				s_d.seen = 1'b1;
			end
			if (s_q.per == 16'(PERIOD_CYC - 1)) begin
				s_d.per = 16'h0000;
				s_d.seen = 1'b0;
				s_d.ok = s_q.seen | edge_ok;
				if (!(s_q.seen | edge_ok)) begin
					s_d.good = 4'h0;
					if (!s_q.safe) begin
						s_d.safe = 1'b1;
						s_d.entry = 1'b1;
					end
				end else if (s_q.safe) begin
					if (s_q.good == 4'(RECOVER - 1)) begin
						s_d.safe = 1'b0;
						s_d.good = 4'h0;
					end else begin
						s_d.good = s_q.good + 4'h1;
					end
				end
			end else begin
				s_d.per = s_q.per + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign g.safe_sel = s_q.safe;
	assign g.safe_entry = s_q.entry;
	assign g.main_ok = s_q.ok;

endmodule

// ===== src/rcs_guard_if.sv
// Signals between the supervisor top and its clock guard.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps

interface rcs_guard_if;
	logic en;
	logic osc_lvl;
	logic safe_sel;
	logic safe_entry;
	logic main_ok;

	modport ctrl (output en, output osc_lvl, input safe_sel, input safe_entry, input main_ok);
	modport guard (input en, input osc_lvl, output safe_sel, output safe_entry, output main_ok);
endinterface

// ===== src/rcs_pin_sync.sv
// Three-stage synchroniser for pins from outside the core clock domain.
// Assumes inputs may change at any time; output follows once stages 2 and 3 agree.
`timescale 1ns/1ps

module rcs_pin_sync import rcs_pkg::*; #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] lvl;
	} rcs_sync_s;

	rcs_sync_s s_q;
	rcs_sync_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.ff1 = pin;
		s_d.ff2 = s_q.ff1;
		s_d.ff3 = s_q.ff2;
		s_d.lvl = (s_q.ff2 & ~(s_q.ff2 ^ s_q.ff3)) | (s_q.lvl & (s_q.ff2 ^ s_q.ff3));
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.lvl;

endmodule

// ===== src/rcs_pkg.sv
// Constants, register layout and timing counts of the reset and clock supervisor.
// Assumes a 100 MHz core clock; the cycle counts below are derived from it.
//
// Summary of operation
// - A low level on the reset pin is caught asynchronously, even with clocks halted.
// - After a caught external reset, the pin is driven low for the minimum output width.
// - While the supply is below the detector threshold the pin is held low.
// - A watchdog underflow drives the pin low for the minimum output width.
// - The main oscillator is kept running throughout the reset phase.
// - Short spikes on the main clock are filtered; filtering runs whenever the guard is enabled.
// - A main clock missing for one safe-oscillator period selects the safe clock.
// - When the main clock recovers, the system clock returns to it automatically.
// - The detection flag is set whenever hardware selects the safe clock.
// - Interrupt only when detection flag, its enable set and core mask clear.
// - In wait mode the clock guard runs unchanged and its interrupt wakes the core.
// - In halt the status register is frozen and the clock guard is off.
// - After halt, interrupt wake keeps configuration; reset wake restores reset values.
// - The guard interrupt wakes active-halt, never plain halt.
// - Status bits 7 to 5 and bit 3 always read as zero.
// - Bit 4 is set on a low-voltage reset; software clears it writing zero.
// - With the low-voltage detector disabled, bit 4 carries no meaningful value.
// - Bit 2 is the read/write enable of the clock guard interrupt.
// - With the guard disabled by option byte, the interrupt enable has no effect.
// - Bit 1 is set on safe clock selection; a read clears it after recovery.
// - With the guard disabled by option byte, bit 1 reads as zero.
// - The clock guard as a whole is enabled by an option byte input only.
// - Bit 0 is set on watchdog reset; cleared by writing zero or low-voltage reset.
// - Bit 4 survives later external and watchdog resets.

package rcs_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;

	// Register index as printed; byte address is four times it
	localparam logic [7:0] STATUS_IDX = 8'h2B;
	localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};
	localparam logic [7:0] STATUS_RESET = 8'h00;

	localparam int unsigned BIT_LVD_FLAG = 4;
	localparam int unsigned BIT_IRQ_EN = 2;
	localparam int unsigned BIT_DETECT = 1;
	localparam int unsigned BIT_WDG_FLAG = 0;

	// Minimum reset output pulse, rounded up
	localparam int unsigned RST_OUT_NS = 20000;
	localparam int unsigned RST_OUT_CYC = (RST_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Safe oscillator period, rounded down
	localparam int unsigned SAFE_OSC_NS = 2000;
	localparam int unsigned SAFE_CYC = SAFE_OSC_NS / CLK_PERIOD_NS;
	// Shortest main clock phase that is not a spike, rounded up
	localparam int unsigned FILTER_NS = 40;
	localparam int unsigned FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Good safe periods needed before switching back
	localparam int unsigned RECOVER_PERIODS = 4;

	typedef enum logic [1:0] {
		PIN_IDLE = 2'b00,
		PIN_DRIVE = 2'b01,
		PIN_RELEASE = 2'b10
	} rcs_pin_e;

endpackage

// ===== src/rcs_supervisor.sv
// Reset and clock supervisor top: reset pin control, status register on AHB-Lite,
// clock guard interrupt and low power handling.
// Assumes the register bus, core mode signals and watchdog run on core_clk; the reset
// pin, supply detector and main oscillator are asynchronous.
`timescale 1ns/1ps

module rcs_supervisor import rcs_pkg::*; #(
	parameter int unsigned OUT_CYC = RST_OUT_CYC
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe,
	input wire logic lvd_below,
	input wire logic opt_lvd_en,
	input wire logic opt_guard_en,
	input wire logic wdg_underflow,
	input wire logic osc_main_i,
	input wire logic halt_mode,
	input wire logic active_halt,
	input wire logic wait_mode,
	input wire logic core_imask,
	output logic sys_rst_n,
	output logic osc_run_en,
	output logic safe_clk_sel,
	output logic main_clk_ok,
	output logic guard_irq,
	output logic wake_req
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------

	typedef struct packed {
		rcs_pin_e pin_st;
		logic [15:0] cnt;
		logic catch_prev;
		logic lvd_prev;
		logic lvd_flag;
		logic wdg_flag;
		logic irq_en;
		logic detect;
		logic dph_sel;
		logic dph_wr;
		logic [7:0] rdata;
		logic osc_run;
		logic rst_hold;
		logic irq;
		logic wake;
	} rcs_top_s;

	rcs_top_s s_q;
	rcs_top_s s_d;

	logic catch_q;
	logic catch_clr;
	logic [2:0] sync_lvl;
	logic lvd_s;
	logic pin_s;
	logic catch_s;
	logic lvd_active;
	logic lvd_rise;
	logic catch_rise;
	logic reset_evt;
	logic addr_acc;
	logic addr_hit;
	logic sw_wr;
	logic sw_rd;
	logic [7:0] wbyte;
	logic irq_cond;

	rcs_guard_if gif ();

	// ------------------------------------------------------------
	// Asynchronous reset pin capture
	// ------------------------------------------------------------

	// Sets with no clock so a pulse is seen even in halt
	always_ff @(posedge core_clk or negedge arst_n or negedge rst_pin_i) begin
		if (!arst_n) begin
			catch_q <= 1'b0;
		end else if (!rst_pin_i) begin
			catch_q <= 1'b1;
		end else if (catch_clr) begin
			catch_q <= 1'b0;
		end
	end

	// Released only once the pin is high again and no drive is pending
	assign catch_clr = (s_q.pin_st == PIN_IDLE) && pin_s && !lvd_active;

	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------

	rcs_pin_sync #(
		.W(3),
		.RESET_VAL(3'b010)
	) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.pin({lvd_below, rst_pin_i, catch_q}),
		.level(sync_lvl)
	);

	assign lvd_s = sync_lvl[2];
	assign pin_s = sync_lvl[1];
	assign catch_s = sync_lvl[0];

	rcs_pin_sync #(
		.W(1),
		.RESET_VAL(1'b0)
	) u_osc_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.pin(osc_main_i),
		.level(gif.osc_lvl)
	);

	// ------------------------------------------------------------
	// Clock guard
	// ------------------------------------------------------------

	assign gif.en = opt_guard_en && !halt_mode;

	rcs_clock_guard u_guard (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.g(gif.guard)
	);

	// ------------------------------------------------------------
	// Events
	// ------------------------------------------------------------

	assign lvd_active = lvd_s && opt_lvd_en;
	assign lvd_rise = lvd_active && !s_q.lvd_prev;
	assign catch_rise = catch_s && !s_q.catch_prev;
	assign reset_evt = lvd_rise || ((s_q.pin_st == PIN_IDLE) && (catch_rise || wdg_underflow));

	// ------------------------------------------------------------
	// AHB-Lite decode
	// ------------------------------------------------------------

	assign addr_acc = hsel && htrans[1] && hready;

	// Only the status word is mapped; every other word reads as zero
	always_comb begin
		addr_hit = 1'b0;
		if (haddr[31:12] != 20'h00000) begin
			addr_hit = 1'b0;
		end else if (haddr[11:0] == STATUS_ADDR) begin
			addr_hit = 1'b1;
		end else begin
			addr_hit = 1'b0;
		end
	end
	assign sw_wr = s_q.dph_sel && s_q.dph_wr && !halt_mode;
	assign sw_rd = addr_acc && addr_hit && !hwrite && !halt_mode;
	assign wbyte = hwdata[7:0];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	always_comb begin
		s_d = s_q;
		s_d.catch_prev = catch_s;
		s_d.lvd_prev = lvd_active;

		// Reset pin drive sequencer
		case (s_q.pin_st)
			PIN_IDLE: begin
				if (catch_rise || wdg_underflow) begin
					s_d.pin_st = PIN_DRIVE;
					s_d.cnt = 16'(OUT_CYC - 1);
				end
			end
			PIN_DRIVE: begin
				if (s_q.cnt == 16'h0000) begin
					s_d.pin_st = PIN_RELEASE;
				end else begin
					s_d.cnt = s_q.cnt - 16'h0001;
				end
			end
			PIN_RELEASE: begin
				// Wait for the external pull-up before arming again
				if (pin_s && !lvd_active) begin
					s_d.pin_st = PIN_IDLE;
				end
			end
			default: begin
				s_d.pin_st = PIN_IDLE;
			end
		endcase
		s_d.rst_hold = (s_d.pin_st != PIN_IDLE) || lvd_active;

		// Low-voltage flag: only a low-voltage reset sets it
		if (lvd_rise) begin
			s_d.lvd_flag = 1'b1;
		end else if (sw_wr && !wbyte[BIT_LVD_FLAG]) begin
			s_d.lvd_flag = 1'b0;
		end

		// Watchdog flag: set wins over both clears
		if (wdg_underflow) begin
			s_d.wdg_flag = 1'b1;
		end else if (lvd_rise || (sw_wr && !wbyte[BIT_WDG_FLAG])) begin
			s_d.wdg_flag = 1'b0;
		end

		// Interrupt enable returns to reset value on any reset
		if (reset_evt) begin
			s_d.irq_en = 1'b0;
		end else if (sw_wr) begin
			s_d.irq_en = wbyte[BIT_IRQ_EN];
		end

		// Data phase ends, next address phase may start
		s_d.dph_sel = addr_acc && addr_hit;
		s_d.dph_wr = hwrite;
		s_d.rdata = 8'h00;
		if (sw_rd) begin
			s_d.rdata[BIT_LVD_FLAG] = s_d.lvd_flag;
			s_d.rdata[BIT_IRQ_EN] = s_d.irq_en;
			s_d.rdata[BIT_DETECT] = s_q.detect && opt_guard_en;
			s_d.rdata[BIT_WDG_FLAG] = s_d.wdg_flag;
		end

		// Detection flag: set wins over the read clear
		if (!opt_guard_en) begin
			s_d.detect = 1'b0;
		end else if (gif.safe_entry) begin
			s_d.detect = 1'b1;
		end else if (reset_evt) begin
			s_d.detect = 1'b0;
		end else if (sw_rd && !gif.safe_sel) begin
			s_d.detect = 1'b0;
		end

		// Interrupt request and wake-up
		s_d.irq = irq_cond;
		s_d.wake = irq_cond && (wait_mode || (halt_mode && active_halt));

		// Oscillator stays on through reset; only plain halt may stop it
		s_d.osc_run = s_d.rst_hold || catch_s || !halt_mode || active_halt;
	end

	// Guard interrupt, blocked in plain halt
	always_comb begin
		irq_cond = s_q.detect && s_q.irq_en && opt_guard_en && !core_imask;
		if (halt_mode && !active_halt) begin
			irq_cond = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.pin_st <= PIN_IDLE;
			s_q.lvd_flag <= STATUS_RESET[BIT_LVD_FLAG];
			s_q.wdg_flag <= STATUS_RESET[BIT_WDG_FLAG];
			s_q.irq_en <= STATUS_RESET[BIT_IRQ_EN];
			s_q.detect <= STATUS_RESET[BIT_DETECT];
			s_q.osc_run <= 1'b1;
			s_q.rst_hold <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = {24'h000000, s_q.rdata};

	// Open-drain pin: drives low only
	assign rst_pin_o = 1'b0;
	assign rst_pin_oe = (s_q.pin_st == PIN_DRIVE) || s_q.rst_hold && lvd_s && opt_lvd_en;
	assign sys_rst_n = !(catch_q || s_q.rst_hold);

	assign osc_run_en = s_q.osc_run;
	assign safe_clk_sel = gif.safe_sel;
	assign main_clk_ok = gif.main_ok;
	assign guard_irq = s_q.irq;
	assign wake_req = s_q.wake;

endmodule

// ===== test/rcs_far_side.sv
// Far side model: main oscillator and external reset circuitry.
// Assumes the bench commands oscillator stops and external pulls.
`timescale 1ns/1ps

module rcs_far_side (
	input wire logic run,
	input wire logic stop,
	input wire logic pull,
	input wire logic oe,
	output logic pin,
	output logic osc
);
	// Open drain wire with pull-up
	assign pin = (pull || oe) ? 1'b0 : 1'b1;
	initial begin
		osc = 1'b0;
		forever begin
			#57;
			if (run && !stop) begin
				osc = ~osc;
			end
		end
	end
endmodule

// ===== test/rcs_supervisor_asserts.sv
// Checker bound to the supervisor top: read data, reset pin drive and guard interrupt.
// Assumes it sees only the top ports, all on core_clk with arst_n.
`timescale 1ns/1ps

module rcs_supervisor_asserts #(
	parameter int unsigned OUT_CYC = 8
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [31:0] hrdata,
	input wire logic rst_pin_i,
	input wire logic rst_pin_oe,
	input wire logic lvd_below,
	input wire logic opt_lvd_en,
	input wire logic opt_guard_en,
	input wire logic wdg_underflow,
	input wire logic halt_mode,
	input wire logic active_halt,
	input wire logic wait_mode,
	input wire logic core_imask,
	input wire logic sys_rst_n,
	input wire logic osc_run_en,
	input wire logic guard_irq,
	input wire logic wake_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// -----------------------------
	// Pin drive, sized for OUT_CYC 8
	// -----------------------------
	sequence drive_start;
		$rose(rst_pin_oe) && !lvd_below;
	endsequence
	sequence drive_hold;
		rst_pin_oe [*8];
	endsequence
	reserved_zero_a: assert property ((hrdata & 32'hFFFF_FFE8) == 32'h0)
		else $error("reserved bits set");
	pin_reset_a: assert property (!rst_pin_i |-> !sys_rst_n)
		else $error("pin low, no reset");
	wdg_drive_a: assert property (wdg_underflow && sys_rst_n && !rst_pin_oe |=> rst_pin_oe)
		else $error("watchdog not driven");
	pulse_width_a: assert property (drive_start |-> drive_hold)
		else $error("pulse too short");
	lvd_hold_a: assert property ((lvd_below && opt_lvd_en) [*6] |-> rst_pin_oe)
		else $error("pin free in low supply");
	osc_run_a: assert property (!sys_rst_n |-> osc_run_en)
		else $error("oscillator stopped");
	irq_cond_a: assert property (guard_irq |-> $past(opt_guard_en) && !$past(core_imask))
		else $error("irq without cause");
	irq_halt_a: assert property (guard_irq |-> !($past(halt_mode) && !$past(active_halt)))
		else $error("irq in halt");
	wake_cond_a: assert property (wake_req |-> guard_irq && ($past(wait_mode) || $past(active_halt)))
		else $error("wake without cause");
	halt_read_a: assert property ($past(halt_mode) |-> hrdata == 32'h0)
		else $error("read in halt");
	detect_off_a: assert property (!opt_guard_en && !$past(opt_guard_en) |-> !hrdata[1])
		else $error("detect with guard off");
endmodule

bind rcs_supervisor rcs_supervisor_asserts #(.OUT_CYC(OUT_CYC)) i_rcs_supervisor_asserts (
	.core_clk, .arst_n, .hrdata, .rst_pin_i, .rst_pin_oe, .lvd_below, .opt_lvd_en,
	.opt_guard_en, .wdg_underflow, .halt_mode, .active_halt, .wait_mode, .core_imask,
	.sys_rst_n, .osc_run_en, .guard_irq, .wake_req
);

// ===== test/tb_top.sv
// Self-checking bench for the supervisor: register table, reset pin, clock guard.
// Assumes the far side model and the bound checker.
`timescale 1ns/1ps

module tb_top import rcs_pkg::*;;
	typedef struct {logic [31:0] a; logic [7:0] w; logic [7:0] e;} rcs_row_s;
	localparam logic [31:0] SA = {20'h0, STATUS_ADDR};
	logic core_clk, arst_n, hsel, hwrite, hreadyout, hresp, rst_pin_i, rst_pin_o, rst_pin_oe;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic lvd_below, opt_lvd_en, opt_guard_en, wdg_underflow, osc_main_i, halt_mode, active_halt;
	logic wait_mode, core_imask, sys_rst_n, osc_run_en, safe_clk_sel, main_clk_ok;
	logic guard_irq, wake_req, osc_stop, ext_pull;
	logic [7:0] r;
	int error_cnt, cmp_count;
	rcs_row_s rows [4] = '{'{SA, 8'hFF, 8'h04}, '{SA, 8'hFB, 8'h00}, '{SA, 8'h04, 8'h04},
		'{32'hB0, 8'hFF, 8'h00}};

	rcs_supervisor #(.OUT_CYC(8)) i_rcs_supervisor (.core_clk, .arst_n, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .lvd_below, .opt_lvd_en,
		.opt_guard_en, .wdg_underflow, .osc_main_i, .halt_mode, .active_halt, .wait_mode,
		.core_imask, .sys_rst_n, .osc_run_en, .safe_clk_sel, .main_clk_ok, .guard_irq,
		.wake_req);
	rcs_far_side i_rcs_far_side (.run(osc_run_en), .stop(osc_stop), .pull(ext_pull),
		.oe(rst_pin_oe), .pin(rst_pin_i), .osc(osc_main_i));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// -----------------------------
	// Checks, waits and bus cycles
	// -----------------------------
	task automatic report_and_stop();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic wait_sig(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		if (s !== v) begin
			error_cnt++;
			$display("[ERR] wait exp %b got %b", v, s);
			report_and_stop();
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge core_clk);
		wait_sig(hreadyout, 1'b1, 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge core_clk);
		wait_sig(hreadyout, 1'b1, 50);
		r = hrdata[7:0];
	endtask
	task automatic wdg_pulse();
		@(posedge core_clk);
		wdg_underflow <= 1'b1;
		@(posedge core_clk);
		wdg_underflow <= 1'b0;
		wait_sig(rst_pin_oe, 1'b1, 10);
		wait_sig(sys_rst_n, 1'b1, 100);
	endtask

	// -----------------------------
	// Main sequence
	// -----------------------------
	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		lvd_below = 1'b0;
		opt_guard_en = 1'b1;
		opt_lvd_en = 1'b1;
		wdg_underflow = 1'b0;
		halt_mode = 1'b0;
		active_halt = 1'b0;
		wait_mode = 1'b0;
		core_imask = 1'b0;
		osc_stop = 1'b0;
		ext_pull = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		wait_sig(sys_rst_n, 1'b1, 20);
		foreach (rows[i]) begin
			bus(rows[i].a, 1'b1, rows[i].w);
			bus(rows[i].a, 1'b0, 8'h00);
			chk_reg("row", rows[i].e, r);
		end
		$display("test rows done");
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		wait_sig(sys_rst_n, 1'b1, 20);
		bus(SA, 1'b0, 8'h00);
		chk_reg("reset", STATUS_RESET, r);
		$display("test reset done");
		bus(SA, 1'b1, 8'h04);
		wdg_pulse();
		chk_bit("pin out", 1'b0, rst_pin_o);
		bus(SA, 1'b0, 8'h00);
		chk_reg("wdg", 8'h01, r);
		bus(SA, 1'b1, 8'h00);
		bus(SA, 1'b0, 8'h00);
		chk_reg("wdg clr", 8'h00, r);
		$display("test watchdog done");
		@(posedge core_clk);
		lvd_below <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk_bit("lvd oe", 1'b1, rst_pin_oe);
		lvd_below <= 1'b0;
		wait_sig(sys_rst_n, 1'b1, 100);
		bus(SA, 1'b0, 8'h00);
		chk_reg("lvd", 8'h10, r);
		wdg_pulse();
		bus(SA, 1'b0, 8'h00);
		chk_reg("lvd wdg", 8'h11, r);
		ext_pull <= 1'b1;
		@(posedge core_clk);
		chk_bit("ext rst", 1'b0, sys_rst_n);
		repeat (5) @(posedge core_clk);
		ext_pull <= 1'b0;
		wait_sig(sys_rst_n, 1'b1, 100);
		bus(SA, 1'b0, 8'h00);
		chk_reg("lvd ext", 8'h11, r);
		bus(SA, 1'b1, 8'h00);
		bus(SA, 1'b0, 8'h00);
		chk_reg("lvd clr", 8'h00, r);
		$display("test supply done");
		bus(SA, 1'b1, 8'h04);
		osc_stop <= 1'b1;
		wait_sig(safe_clk_sel, 1'b1, 600);
		chk_bit("clk lost", 1'b0, main_clk_ok);
		wait_sig(guard_irq, 1'b1, 5);
		bus(SA, 1'b0, 8'h00);
		chk_reg("detect", 8'h06, r);
		wait_mode <= 1'b1;
		wait_sig(wake_req, 1'b1, 5);
		wait_mode <= 1'b0;
		core_imask <= 1'b1;
		wait_sig(guard_irq, 1'b0, 5);
		core_imask <= 1'b0;
		halt_mode <= 1'b1;
		active_halt <= 1'b1;
		wait_sig(wake_req, 1'b1, 5);
		active_halt <= 1'b0;
		wait_sig(guard_irq, 1'b0, 5);
		bus(SA, 1'b1, 8'h00);
		bus(SA, 1'b0, 8'h00);
		chk_reg("halt rd", 8'h00, r);
		halt_mode <= 1'b0;
		wait_sig(safe_clk_sel, 1'b1, 400);
		bus(SA, 1'b0, 8'h00);
		chk_reg("after halt", 8'h06, r);
		osc_stop <= 1'b0;
		wait_sig(safe_clk_sel, 1'b0, 2000);
		chk_bit("clk back", 1'b1, main_clk_ok);
		bus(SA, 1'b0, 8'h00);
		chk_reg("detect rd", 8'h06, r);
		bus(SA, 1'b0, 8'h00);
		chk_reg("read clr", 8'h04, r);
		$display("test guard done");
		osc_stop <= 1'b1;
		wait_sig(guard_irq, 1'b1, 700);
		opt_guard_en <= 1'b0;
		opt_lvd_en <= 1'b0;
		lvd_below <= 1'b1;
		repeat (300) @(posedge core_clk);
		chk_bit("lvd off", 1'b0, rst_pin_oe);
		lvd_below <= 1'b0;
		chk_bit("safe off", 1'b0, safe_clk_sel);
		chk_bit("irq off", 1'b0, guard_irq);
		bus(SA, 1'b0, 8'h00);
		chk_bit("detect off", 1'b0, r[1]);
		osc_stop <= 1'b0;
		$display("test option done");
		report_and_stop();
	end
endmodule
